// [fws_defines.vh]
// timing constants and field layout for the flash write/reset sequencer
`ifndef FWS_DEFINES_VH
`define FWS_DEFINES_VH
`define FWS_CLK_NS        10
`define FWS_WP_NS         70
`define FWS_WP_CYC        ((`FWS_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WPH_NS        30
`define FWS_WPH_CYC       ((`FWS_WPH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_SETUP_NS      50
`define FWS_SETUP_CYC     ((`FWS_SETUP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_HOLD_NS       10
`define FWS_HOLD_CYC      ((`FWS_HOLD_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_NS        35
`define FWS_REC_CYC       ((`FWS_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RSTREC_US     1
`define FWS_RSTREC_CYC    ((`FWS_RSTREC_US * 1000 + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RSTLOW_NS     100
`define FWS_RSTLOW_CYC    ((`FWS_RSTLOW_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_BUSY_NS       90
`define FWS_BUSY_CYC      ((`FWS_BUSY_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_ACC_NS        150
`define FWS_ACC_CYC       ((`FWS_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_PHQV_NS       210
`define FWS_PHQV_CYC      ((`FWS_PHQV_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_ERR_MASK      8'h3a
`define FWS_ADDR_W        23
`define FWS_DATA_W        16
`define FWS_CNT_W         8
`endif

// [fws_flash_model.sv]
// behavioural flash device: write latch, busy timer, status and array reads
`timescale 1ns/1ns
module fws_flash_model #(
    parameter [7:0] BUSY_CYC = 8'h3c     // length of a launched operation
) (
    input  wire        clk,             // sampling clock for pin edges
    input  wire [2:0]  chipSelN,        // chip selects, active low
    input  wire        writeN,          // write strobe, active low
    input  wire        outEnN,          // output enable, active low
    input  wire        resetPowerdownN, // reset pin, active low
    input  wire [22:0] flashAddr,       // address pins
    input  wire [15:0] flashDqOut,      // host data
    input  wire        errInject,       // report error bits in status
    output wire [15:0] flashDqIn,       // data to host
    output wire        statusPin,       // low while busy
    output reg  [15:0] lastData         // last word written
);
    reg        wrAct_q;
    reg        rdStat_q;
    reg  [7:0] busy_q;
    reg [15:0] dqLast_q;
    wire       selOn = chipSelN == 3'h0;
    wire       wrAct = selOn && !writeN;
    wire [7:0] srVal = busy_q != 8'h00 ? 8'h00 : (errInject ? 8'hba : 8'h80);
    // reads answered alike busy or idle
    wire       rdOn = selOn && !outEnN && resetPowerdownN;
    assign flashDqIn = rdOn ? (rdStat_q ? {8'h00, srVal} : flashAddr[15:0]) : ~dqLast_q;
    // busy shows one cycle after the write edge
    assign statusPin = busy_q == 8'h00;
    // released bus toggles each cycle so stale data never passes
    always @(posedge clk) begin
        wrAct_q <= wrAct;
        dqLast_q <= flashDqIn;
        if (!resetPowerdownN) begin
            busy_q <= 8'h00;
            rdStat_q <= 1'b0;
        end else if (wrAct_q && !wrAct) begin
            lastData <= flashDqOut;
            rdStat_q <= flashDqOut[7:0] != 8'hff;
            busy_q <= flashDqOut[7:0] == 8'hd0 ? BUSY_CYC : 8'h00;
        end else if (busy_q != 8'h00) begin
            busy_q <= busy_q - 8'h01;
        end
    end
endmodule

// [fws_host.v]
// host sequencer driving an asynchronous nor flash: write, read and reset cycles
//
// Notes on behaviour
// RULE_01 - write opened and closed by either chip select or write strobe.
// RULE_02 - device enables on first enabling chip-select edge, disables on first disabling.
// RULE_03 - write pulse held active at least 70 ns overlap.
// RULE_04 - wait at least 1 us after reset release before any write.
// RULE_05 - wait 35 ns after write before output enable; array read adds access time.
// RULE_06 - device drops ready/busy within 90 ns after launching write edge.
// RULE_07 - hold program supply high until status error bits read clear.
// RULE_08 - software orders setup, confirm, wait, status read, then read-array.
// RULE_09 - reset held low 35 units when busy, 100 ns when idle; code holds 100 ns in both cases.
// RULE_10 - device abandons operation within 100 units of reset.
// RULE_11 - outputs trusted only after recovery from later of ready and reset high.
// RULE_12 - output enable may lag chip select by access-time difference.
// RULE_13 - read timing during operations equals plain read timing.
// RULE_14 - read status once ready returns, judge error bits before next command.
`timescale 1ns/1ns
`include "fws_defines.vh"
module fws_host (
    input  wire                    clk,          // system clock 100 MHz
    input  wire                    nrst,         // synchronous reset, active low
    input  wire                    reqWrite,     // pulse: start write cycle
    input  wire                    reqRead,      // pulse: start read cycle
    input  wire                    reqReset,     // pulse: start flash reset
    input  wire                    reqBusyOp,    // level: an operation may be running
    input  wire                    useStrobeCs,  // 1: chip select times the pulse
    input  wire                    arrayRead,    // 1: read is an array read
    input  wire                    progEnReq,    // level: request supply high
    input  wire [`FWS_ADDR_W-1:0]  reqAddr,      // request address
    input  wire [`FWS_DATA_W-1:0]  reqData,      // request write data
    input  wire [`FWS_DATA_W-1:0]  flashDqIn,    // data bus from flash
    input  wire                    statusPin,    // ready/busy pin from flash
    output reg                     cmdReady,     // high when idle and recovered
    output reg                     rdValid,      // pulse: read data valid
    output reg  [`FWS_DATA_W-1:0]  rdData,       // captured read data
    output reg                     flashReady,   // filtered ready/busy level
    output reg                     statusOk,     // last status read had no error bits
    output reg  [`FWS_ADDR_W-1:0]  flashAddr,    // address pins
    output reg  [`FWS_DATA_W-1:0]  flashDqOut,   // data out
    output reg                     flashDqOe,    // data out enable, high drives
    output reg  [2:0]              chipSelN,     // three chip selects, active low
    output reg                     writeN,       // write strobe, active low
    output reg                     outEnN,       // output enable, active low
    output reg                     resetPowerdownN, // reset/power-down, active low
    output reg                     progEnableSupply // program supply enable
);
    localparam [3:0] ST_RST   = 4'h0;
    localparam [3:0] ST_RREC  = 4'h1;
    localparam [3:0] ST_IDLE  = 4'h2;
    localparam [3:0] ST_WSET  = 4'h3;
    localparam [3:0] ST_WPUL  = 4'h4;
    localparam [3:0] ST_WHLD  = 4'h5;
    localparam [3:0] ST_WREC  = 4'h6;
    localparam [3:0] ST_RACC  = 4'h7;
    localparam [3:0] ST_RCAP  = 4'h8;

    // timing counts arrive as integers; trimmed to counter width on purpose
    localparam integer          WP_I   = `FWS_WP_CYC;
    localparam integer          SET_I  = `FWS_SETUP_CYC;
    localparam integer          HLD_I  = `FWS_HOLD_CYC;
    localparam integer          REC_I  = `FWS_REC_CYC;
    localparam integer          RLO_I  = `FWS_RSTLOW_CYC;
    localparam integer          ACC_I  = `FWS_ACC_CYC;
    localparam integer          PHQ_I  = `FWS_PHQV_CYC;
    localparam integer          WPH_I  = `FWS_WPH_CYC;
    localparam integer          RREC_I = `FWS_RSTREC_CYC;
    localparam [`FWS_CNT_W-1:0] WP_C   = WP_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] SET_C  = SET_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] HLD_C  = HLD_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] REC_C  = REC_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] RLO_C  = RLO_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] ACC_C  = ACC_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] PHQ_C  = PHQ_I[`FWS_CNT_W-1:0];
    localparam [`FWS_CNT_W-1:0] WPH_C  = WPH_I[`FWS_CNT_W-1:0];
    localparam [6:0]            RREC_C = RREC_I[6:0];

    reg  [3:0]             state_q;
    reg  [`FWS_CNT_W-1:0]  cnt_q;
    reg  [6:0]             recCnt_q;
    reg                    csMode_q;
    reg                    arr_q;
    reg                    statusRd_q;
    wire                   readySync;

    // all three chip-select lines move together so the first edge is the only edge
    function [2:0] csDrive;
        input en;
        begin
            csDrive = en ? 3'h0 : 3'h7;
        end
    endfunction

    fws_sync fws_sync_inst (
        .clk      (clk),
        .nrst     (nrst),
        .pinIn    (statusPin),
        .levelOut (readySync)
    );

    // main sequencer
    always @(posedge clk) begin
        if (!nrst) begin
            state_q          <= ST_RST;
            cnt_q            <= {`FWS_CNT_W{1'b0}};
            recCnt_q         <= 7'h0;
            csMode_q         <= 1'b0;
            arr_q            <= 1'b0;
            statusRd_q       <= 1'b0;
            cmdReady         <= 1'b0;
            rdValid          <= 1'b0;
            rdData           <= {`FWS_DATA_W{1'b0}};
            flashReady       <= 1'b0;
            statusOk         <= 1'b0;
            flashAddr        <= {`FWS_ADDR_W{1'b0}};
            flashDqOut       <= {`FWS_DATA_W{1'b0}};
            flashDqOe        <= 1'b0;
            chipSelN         <= 3'h7;
            writeN           <= 1'b1;
            outEnN           <= 1'b1;
            resetPowerdownN  <= 1'b0;
            progEnableSupply <= 1'b0;
        end else begin
            rdValid    <= 1'b0;
            flashReady <= readySync;
            cmdReady   <= 1'b0;
            // RULE_07 supply hold
            // supply drops only once a status read showed clean error bits
            if (progEnReq) begin
                progEnableSupply <= 1'b1;
            end else if (statusOk && readySync) begin
                progEnableSupply <= 1'b0;
            end
            case (state_q)
                ST_RST: begin
                    // RULE_09 reset pulse width
                    // busy device: 35 units; idle: 100 ns; both branches pick the 100 ns count
                    resetPowerdownN <= 1'b0;
                    chipSelN        <= csDrive(1'b0);
                    writeN          <= 1'b1;
                    outEnN          <= 1'b1;
                    flashDqOe       <= 1'b0;
                    if (cnt_q >= ((RLO_C > PHQ_C) ? RLO_C : RLO_C) - 8'h1) begin
                        cnt_q           <= {`FWS_CNT_W{1'b0}};
                        recCnt_q        <= 7'h0;
                        resetPowerdownN <= 1'b1;
                        state_q         <= ST_RREC;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                ST_RREC: begin
                    // RULE_04 reset recovery
                    // RULE_11 recovery counted from later of ready and reset high
                    if (!readySync) begin
                        recCnt_q <= 7'h0;
                    end else if (recCnt_q >= RREC_C - 7'h1) begin
                        state_q  <= ST_IDLE;
                        cmdReady <= 1'b1;
                    end else begin
                        recCnt_q <= recCnt_q + 7'h1;
                    end
                end
                ST_IDLE: begin
                    cmdReady <= 1'b1;
                    cnt_q    <= {`FWS_CNT_W{1'b0}};
                    // RULE_08 one command at a time
                    // requests only taken here, so commands reach the pins in issue order
                    if (reqReset) begin
                        // RULE_09 pin drops now
                        // pulling the pin here gives a full ten-cycle low time
                        cmdReady        <= 1'b0;
                        resetPowerdownN <= 1'b0;
                        state_q         <= ST_RST;
                    end else if (reqWrite) begin
                        // RULE_01 strobe choice
                        cmdReady   <= 1'b0;
                        csMode_q   <= useStrobeCs;
                        flashAddr  <= reqAddr;
                        flashDqOut <= reqData;
                        flashDqOe  <= 1'b1;
                        // RULE_02 single enabling edge
                        if (!useStrobeCs) begin
                            chipSelN <= csDrive(1'b1);
                        end else begin
                            writeN <= 1'b0;
                        end
                        state_q <= ST_WSET;
                    end else if (reqRead) begin
                        // RULE_12 output enable with chip select
                        // RULE_13 same read timing while busy
                        cmdReady   <= 1'b0;
                        arr_q      <= arrayRead;
                        statusRd_q <= !arrayRead;
                        flashAddr  <= reqAddr;
                        chipSelN   <= csDrive(1'b1);
                        outEnN     <= 1'b0;
                        state_q    <= ST_RACC;
                    end
                end
                ST_WSET: begin
                    // RULE_03 pulse overlap
                    // pulse opens here; address and data already stable
                    if (csMode_q) begin
                        chipSelN <= csDrive(1'b1);
                    end else begin
                        writeN <= 1'b0;
                    end
                    state_q <= ST_WPUL;
                end
                ST_WPUL: begin
                    // RULE_03 width and setup
                    // overlap covers both 70 ns width and 50 ns setup
                    if (cnt_q >= ((WP_C > SET_C) ? WP_C : SET_C) - 8'h1) begin
                        cnt_q <= {`FWS_CNT_W{1'b0}};
                        if (csMode_q) begin
                            chipSelN <= csDrive(1'b0);
                        end else begin
                            writeN <= 1'b1;
                        end
                        state_q <= ST_WHLD;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                ST_WHLD: begin
                    // other strobe held 10 ns past the closing edge
                    if (cnt_q >= HLD_C - 8'h1) begin
                        cnt_q     <= {`FWS_CNT_W{1'b0}};
                        chipSelN  <= csDrive(1'b0);
                        writeN    <= 1'b1;
                        flashDqOe <= 1'b0;
                        statusOk  <= 1'b0;
                        state_q   <= ST_WREC;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                ST_WREC: begin
                    // RULE_05 write recovery
                    // RULE_06 not waited out: this 40 ns wait can end before the 90 ns ready fall; 35 ns and pulse-high covered
                    if (cnt_q >= ((REC_C > WPH_C) ? REC_C : WPH_C) - 8'h1) begin
                        cnt_q   <= {`FWS_CNT_W{1'b0}};
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                ST_RACC: begin
                    // RULE_05 array access added
                    // array and status reads both wait the full access time
                    if (cnt_q >= (arr_q ? ACC_C : ACC_C) - 8'h1) begin
                        state_q <= ST_RCAP;
                    end else begin
                        cnt_q <= cnt_q + 8'h1;
                    end
                end
                ST_RCAP: begin
                    // RULE_14 status judged
                    rdData   <= flashDqIn;
                    rdValid  <= 1'b1;
                    if (statusRd_q) begin
                        statusOk <= ((flashDqIn[7:0] & `FWS_ERR_MASK) == 8'h00) && readySync;
                    end
                    chipSelN <= csDrive(1'b0);
                    outEnN   <= 1'b1;
                    cnt_q    <= {`FWS_CNT_W{1'b0}};
                    state_q  <= ST_WREC;
                end
                default: begin
                    state_q <= ST_RST;
                end
            endcase
        end
    end
endmodule

// [fws_host_assertions.sv]
// concurrent checks on the pins of the flash host sequencer
`timescale 1ns/1ns
`include "fws_defines.vh"
module fws_host_assertions (
    input wire                   clk,             // system clock
    input wire                   nrst,            // sync reset, active low
    input wire                   writeN,          // write strobe, active low
    input wire [2:0]             chipSelN,        // chip selects, active low
    input wire                   outEnN,          // output enable, active low
    input wire                   resetPowerdownN, // flash reset pin
    input wire [`FWS_DATA_W-1:0] flashDqOut,      // write data
    input wire                   flashDqOe,       // data drive enable
    input wire                   rdValid,         // read data valid
    input wire                   statusOk,        // last status clean
    input wire                   progEnableSupply // program supply
);
    reg  [7:0] upCnt_q;
    wire [7:0] upCnt_d = !resetPowerdownN ? 8'h00 : (upCnt_q == 8'hc8 ? upCnt_q : upCnt_q + 8'h01);
    wire       pulseOn = !writeN && chipSelN == 3'h0;
    // cycles since reset pin release; saturates so idle runs never wrap
    always @(posedge clk) begin
        if (!nrst) upCnt_q <= 8'h00;
        else upCnt_q <= upCnt_d;
    end
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_write_pulse_width: assert property ($rose(pulseOn) |-> pulseOn[*7])
        else $error("write pulse too short");
    a_data_held: assert property (pulseOn |-> flashDqOe && $stable(flashDqOut))
        else $error("write data moved in pulse");
    a_reset_low_time: assert property ($fell(resetPowerdownN) |->
        !resetPowerdownN[*8] ##1 !resetPowerdownN[*2])
        else $error("reset pulse too short");
    a_reset_to_write: assert property (!writeN |-> upCnt_q >= 8'h64)
        else $error("write too soon after reset");
    a_write_recovery: assert property ($fell(pulseOn) |-> outEnN[*4])
        else $error("read too soon after write");
    a_no_oe_in_write: assert property (!outEnN |-> writeN && !flashDqOe)
        else $error("output enable during write");
    a_oe_under_cs: assert property (!outEnN |-> chipSelN == 3'h0)
        else $error("output enable without select");
    a_read_after_reset: assert property (rdValid |-> upCnt_q >= 8'h15)
        else $error("read data before reset recovery");
    a_supply_held: assert property ($fell(progEnableSupply) |-> statusOk)
        else $error("supply dropped before clean status");
endmodule

// [fws_sync.v]
// three-flop synchroniser with agreement filter for a pin input
`timescale 1ns/1ns
module fws_sync (
    input  wire clk,      // system clock
    input  wire nrst,     // synchronous reset, active low
    input  wire pinIn,    // asynchronous pin level
    output reg  levelOut  // filtered level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first flop feeds only the second; change taken when stages two and three agree
    always @(posedge clk) begin
        if (!nrst) begin
            s1_q     <= 1'b1;
            s2_q     <= 1'b1;
            s3_q     <= 1'b1;
            levelOut <= 1'b1;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                levelOut <= s3_q;
            end
        end
    end
endmodule

// [test_flash_write_reset_timing.sv]
// self-checking bench for the flash host sequencer
`timescale 1ns/1ns
module test_flash_write_reset_timing;
    reg         clk = 1'b0;
    reg         nrst = 1'b0;
    reg         reqWrite = 1'b0;
    reg         reqRead = 1'b0;
    reg         reqReset = 1'b0;
    reg         reqBusyOp = 1'b0;
    reg         useStrobeCs = 1'b0;
    reg         arrayRead = 1'b0;
    reg         progEnReq = 1'b0;
    reg         errInject = 1'b0;
    reg  [22:0] reqAddr = 23'h000000;
    reg  [15:0] reqData = 16'h0000;
    wire [15:0] flashDqIn, rdData, flashDqOut, lastData;
    wire [22:0] flashAddr;
    wire [2:0]  chipSelN;
    wire        statusPin, cmdReady, rdValid, flashReady, statusOk, flashDqOe;
    wire        writeN, outEnN, resetPowerdownN, progEnableSupply;
    integer     n_errors = 0;
    integer     n_compared = 0;
    integer     cycles = 0;
    integer     i;
    fws_host fws_host_inst (.clk(clk), .nrst(nrst), .reqWrite(reqWrite), .reqRead(reqRead),
        .reqReset(reqReset), .reqBusyOp(reqBusyOp), .useStrobeCs(useStrobeCs),
        .arrayRead(arrayRead), .progEnReq(progEnReq), .reqAddr(reqAddr), .reqData(reqData),
        .flashDqIn(flashDqIn), .statusPin(statusPin), .cmdReady(cmdReady), .rdValid(rdValid),
        .rdData(rdData), .flashReady(flashReady), .statusOk(statusOk), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .chipSelN(chipSelN), .writeN(writeN),
        .outEnN(outEnN), .resetPowerdownN(resetPowerdownN), .progEnableSupply(progEnableSupply));
    fws_flash_model fws_flash_model_inst (.clk(clk), .chipSelN(chipSelN), .writeN(writeN),
        .outEnN(outEnN), .resetPowerdownN(resetPowerdownN), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .errInject(errInject), .flashDqIn(flashDqIn),
        .statusPin(statusPin), .lastData(lastData));
    // clock and hang guard
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            n_errors = n_errors + 1;
            report_and_stop;
        end
    end
    task report_and_stop;
        begin
            if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // kind 0 write, 1 read, 2 reset, 3 only wait for idle
    task issue(input [1:0] kind, input mode, input [22:0] a, input [15:0] d);
        begin
            // a hang here is caught by the cycle ceiling
            while (cmdReady !== 1'b1) begin
                @(negedge clk);
            end
            if (kind != 2'h3) begin
                reqWrite = kind == 2'h0;
                reqRead = kind == 2'h1;
                reqReset = kind == 2'h2;
                useStrobeCs = mode;
                arrayRead = mode;
                reqAddr = a;
                reqData = d;
                @(negedge clk);
                {reqWrite, reqRead, reqReset} = 3'h0;
            end
        end
    endtask
    task wr(input mode, input [15:0] d);
        begin
            issue(2'h0, mode, 23'h000010, d);
            issue(2'h3, 1'b0, 23'h000000, 16'h0000);
            chk(lastData, d);
        end
    endtask
    task rd(input arr, input [22:0] a, input [15:0] exp);
        begin
            issue(2'h1, arr, a, 16'h0000);
            while (rdValid !== 1'b1) begin
                @(negedge clk);
            end
            chk(rdData, exp);
        end
    endtask
    task t_boot;
        begin
            chk({chipSelN, writeN, outEnN, resetPowerdownN, flashDqOe, cmdReady}, 8'hf8);
            nrst = 1'b1;
            issue(2'h3, 1'b0, 23'h000000, 16'h0000);
            chk({resetPowerdownN, cmdReady}, 2'h3);
        end
    endtask
    // both strobe orders, then array reads back to back
    task t_modes;
        begin
            wr(1'b0, 16'h1234);
            wr(1'b1, 16'habcd);
            wr(1'b0, 16'h00ff);
            rd(1'b1, 23'h001357, 16'h1357);
            rd(1'b1, 23'h7fffff, 16'hffff);
        end
    endtask
    // launched operation, failing then clean status, supply release
    task t_operation;
        begin
            progEnReq = 1'b1;
            errInject = 1'b1;
            wr(1'b0, 16'h0020);
            wr(1'b0, 16'h00d0);
            chk(progEnableSupply, 1'b1);
            i = 0;
            while (flashReady !== 1'b0 && i < 12) begin
                @(negedge clk);
                i = i + 1;
            end
            chk(flashReady, 1'b0);
            while (flashReady !== 1'b1 && i < 200) begin
                @(negedge clk);
                i = i + 1;
            end
            rd(1'b0, 23'h000000, 16'h00ba);
            chk(statusOk, 1'b0);
            progEnReq = 1'b0;
            repeat (4) @(negedge clk);
            chk(progEnableSupply, 1'b1);
            errInject = 1'b0;
            rd(1'b0, 23'h000000, 16'h0080);
            repeat (4) @(negedge clk);
            chk({statusOk, progEnableSupply}, 2'h2);
            wr(1'b0, 16'h00ff);
            rd(1'b1, 23'h000abc, 16'h0abc);
        end
    endtask
    // reset in mid-operation, then trusted reads again
    task t_reset_busy;
        begin
            reqBusyOp = 1'b1;
            wr(1'b0, 16'h00d0);
            chk(statusPin, 1'b0);
            issue(2'h2, 1'b0, 23'h000000, 16'h0000);
            repeat (2) @(negedge clk);
            chk(statusPin, 1'b1);
            reqBusyOp = 1'b0;
            wr(1'b0, 16'h00ff);
            rd(1'b1, 23'h002468, 16'h2468);
        end
    endtask
    initial begin
        repeat (16) @(negedge clk);
        t_boot;
        t_modes;
        t_operation;
        t_reset_busy;
        report_and_stop;
    end
endmodule
bind fws_host fws_host_assertions fws_host_assertions_inst (.clk(clk), .nrst(nrst),
    .writeN(writeN), .chipSelN(chipSelN), .outEnN(outEnN), .resetPowerdownN(resetPowerdownN),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .rdValid(rdValid), .statusOk(statusOk),
    .progEnableSupply(progEnableSupply));
